// [dv/dscs_checker.sv]
`timescale 1ns/1ns
`default_nettype none
// ==========
// Port checks of the sector sequencer
module dscs_checker (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic [11:0] paddr, // Address
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic intrq, // Interrupt
  input wire logic byte_tick, // Byte strobe
  input wire logic [7:0] dk_byte, // Disk byte
  input wire logic wr_gate, // Write gate
  input wire logic step_out, // Step
  input wire logic eng_id_req, // ID search
  input wire logic eng_rd_req, // Data read
  input wire logic eng_corr_req // Correction
);
  logic [7:0] n_id;
  logic bad_ad;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  assign bad_ad = paddr[11:5] != 7'h00 || paddr[1:0] != 2'h0;
  // ID searches per command, cleared by interrupt
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) n_id <= 8'h00;
    else if (intrq) n_id <= 8'h00;
    else if (eng_id_req) n_id <= n_id + 8'h01;
  end
  sequence s_gate_up; $rose(wr_gate); endsequence
  sequence s_zero; dk_byte == 8'h00; endsequence
  a_gate_zero_first: assert property (s_gate_up |-> s_zero) else $error("gate opened on data");
  a_gate_on_tick: assert property ($changed(wr_gate) |-> $past(byte_tick)) else $error("gate off tick");
  a_step_pulse_hold: assert property ($rose(step_out) |-> step_out [*8]) else $error("short step");
  a_tries_capped: assert property (n_id <= 8'd33) else $error("too many ID searches");
  a_unmapped_err: assert property (psel && penable && bad_ad |-> pslverr && prdata == 32'h0)
    else $error("unmapped not refused");
  a_mapped_ok: assert property (psel && penable && !bad_ad |-> !pslverr) else $error("mapped refused");
  a_zero_wait: assert property (psel && penable |-> pready) else $error("wait state");
  a_one_request: assert property (eng_id_req |-> !eng_rd_req && !eng_corr_req) else $error("two requests");
  a_id_req_pulse: assert property (eng_id_req |=> !eng_id_req) else $error("long ID request");
endmodule
`default_nettype wire

// [dv/dscs_drive_model.sv]
`timescale 1ns/1ns
`default_nettype none
// ==========
// Drive and read engine model
module dscs_drive_model (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset
  input wire logic rdy_en, // Drive ready
  input wire logic miss, // Never find the ID
  input wire logic eng_id_req, // ID search
  input wire logic eng_rd_req, // Data read
  input wire logic eng_corr_req, // Correction
  output logic drv_ready, // Ready pin
  output logic drv_seek_done, // Seek done pin
  output logic drv_write_fault, // Fault pin
  output logic drv_index, // Index pin
  output logic drv_trk0, // Track zero
  output logic byte_tick, // Byte strobe
  output logic eng_id_done, // ID done
  output logic [1:0] eng_id_stat, // ID status
  output logic eng_rd_done, // Read done
  output logic [1:0] eng_rd_stat, // Read status
  output logic eng_corr_done // Correction done
);
  logic [7:0] ph;
  logic [2:0] idp, rdp, cp;
  // Heads stay on cylinder zero, so seeks settle at once
  assign drv_ready = rdy_en;
  assign drv_seek_done = 1'b1;
  assign drv_write_fault = 1'b0;
  assign drv_trk0 = 1'b1;
  assign drv_index = ph == 8'hff;
  assign byte_tick = ph[1:0] == 2'h3;
  assign eng_id_done = idp[2];
  assign eng_id_stat = {1'b0, miss};
  assign eng_rd_done = rdp[2];
  assign eng_rd_stat = 2'h0;
  assign eng_corr_done = cp[2];
  // Delay lines model engine latency
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph <= 8'h00;
      idp <= 3'h0;
      rdp <= 3'h0;
      cp <= 3'h0;
    end else begin
      ph <= ph + 8'h01;
      idp <= {idp[1:0], eng_id_req};
      rdp <= {rdp[1:0], eng_rd_req};
      cp <= {cp[1:0], eng_corr_req};
    end
  end
endmodule
`default_nettype wire

// [dv/dscs_seq_tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
`include "dscs_regs.vh"
module dscs_seq_tb_top;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, intrq, byte_transfer_request, step_out, wr_gate, byte_tick, er, tk_d;
  logic drv_ready, drv_seek_done, drv_write_fault, drv_index, drv_trk0, rdy_en = 1'b0, miss = 1'b0, bad = 1'b0;
  logic eng_id_req, eng_id_done, eng_rd_req, eng_rd_done, eng_corr_req, eng_corr_done;
  logic [1:0] eng_id_stat, eng_rd_stat;
  logic [7:0] dk_byte, ts;
  logic [7:0] wq[$], sq[$];
  int n_mismatch = 0, checked = 0, nid = 0, i;
  always #5 pclk = ~pclk;
  dscs_seq #(.STEP_UNIT_CYC(20)) DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .intrq, .byte_transfer_request, .drv_ready, .drv_seek_done, .drv_write_fault,
    .drv_index, .drv_trk0, .drv_sel(), .head_sel(), .step_out, .step_dir(), .byte_tick, .dk_byte,
    .dk_gen_chk(), .wr_gate, .tgt_cyl(), .tgt_sec(), .rd_long(), .eng_id_req, .eng_id_done, .eng_id_stat,
    .eng_bad_block(bad), .eng_rd_req, .eng_rd_done, .eng_rd_stat, .eng_corr_req, .eng_corr_done,
    .eng_corr_ok(1'b1), .eng_we(1'b0), .eng_addr(10'h000), .eng_wdata(8'h00));
  dscs_drive_model u_drv (.pclk, .presetn, .rdy_en, .miss, .eng_id_req, .eng_rd_req, .eng_corr_req,
    .drv_ready, .drv_seek_done, .drv_write_fault, .drv_index, .drv_trk0, .byte_tick, .eng_id_done,
    .eng_id_stat, .eng_rd_done, .eng_rd_stat, .eng_corr_done);
  // Gated disk bytes, ID search count
  always @(posedge pclk) begin
    if (tk_d === 1'b1 && wr_gate === 1'b1) sq.push_back(dk_byte);
    if (eng_id_req === 1'b1) nid++;
    tk_d <= byte_tick;
  end
  function automatic logic [11:0] ra(input logic [2:0] x);
    return {7'h00, x, 2'h0};
  endfunction
  // Buffer length: sector size, plus 4 if long
  function automatic int blen(input logic [7:0] sdh, input logic lng);
    blen = (sdh[6:5] == 2'b11) ? 128 : (sdh[6:5] == 2'b01) ? 512 : 256;
    if (lng) blen += 4;
  endfunction
  task automatic summarize;
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic wt(ref logic s, input logic v);
    int k;
    for (k = 0; k < 30000 && s !== v; k++) @(posedge pclk);
    if (s !== v) begin
      n_mismatch++;
      summarize();
    end
  endtask
  // APB transfer held until pready high
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    wt(pready, 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Write-type command: load buffer, await end
  task automatic load(input logic [7:0] c);
    apb(1'b1, ra(`DSCS_R_STCMD), c);
    wt(byte_transfer_request, 1'b1);
    wq.delete();
    for (i = 0; i < blen(8'h60, c[1]); i++) begin
      wq.push_back(8'($urandom));
      apb(1'b1, ra(`DSCS_R_DATA), wq[i]);
    end
    @(posedge pclk);
    cmp(byte_transfer_request, 1'b0);
    wt(intrq, 1'b1);
  endtask
  // Read transfer: request up for every byte
  task automatic drain(input int n);
    for (i = 0; i < n; i++) begin
      cmp(byte_transfer_request, 1'b1);
      apb(1'b0, ra(`DSCS_R_DATA), 8'h00);
    end
    @(posedge pclk);
    wt(intrq, 1'b1);
    cmp(byte_transfer_request, 1'b0);
  endtask
  initial begin
    void'($urandom(32'h15e5));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rdy_en <= 1'b1;
    apb(1'b0, 12'h020, 8'h00);
    cmp({er, rd[30:0]}, 32'h80000000);
    apb(1'b1, 12'h00e, 8'h5a);
    cmp(er, 1'b1);
    ts = 8'($urandom);
    apb(1'b1, ra(`DSCS_R_SNUM), ts);
    apb(1'b0, ra(`DSCS_R_SNUM), 8'h00);
    cmp(rd, {24'h0, ts});
    apb(1'b1, ra(`DSCS_R_SDH), 8'h60);
    // Plain write and its gated stream
    load(8'h30);
    apb(1'b0, ra(`DSCS_R_STCMD), 8'h00);
    cmp(rd & 32'h81, 32'h0);
    cmp(sq.size(), 148);
    for (i = 0; i < 141; i++) cmp(sq[i], i < 12 ? 8'h00 : i == 12 ? 8'hf8 : wq[i - 13]);
    // Drive not ready: aborted, read still completes
    rdy_en <= 1'b0;
    repeat (4) @(posedge pclk);
    apb(1'b1, ra(`DSCS_R_STCMD), 8'h20);
    wt(byte_transfer_request, 1'b1);
    apb(1'b0, ra(`DSCS_R_ERRPC), 8'h00);
    cmp(rd, 32'h04);
    drain(blen(8'h60, 1'b0));
    apb(1'b0, ra(`DSCS_R_STCMD), 8'h00);
    cmp(rd[0], 1'b1);
    // DMA long read, then programmed-I/O read
    rdy_en <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b1, ra(`DSCS_R_STCMD), 8'h2a);
    wt(byte_transfer_request, 1'b1);
    cmp(intrq, 1'b0);
    drain(blen(8'h60, 1'b1));
    apb(1'b1, ra(`DSCS_R_STCMD), 8'h20);
    wt(byte_transfer_request, 1'b1);
    cmp(intrq, 1'b1);
    drain(blen(8'h60, 1'b0));
    // ID never found: retries, one restore, then failure
    miss <= 1'b1;
    nid = 0;
    load(8'h30);
    cmp(nid >= 17 && nid <= 32, 1'b1);
    apb(1'b0, ra(`DSCS_R_ERRPC), 8'h00);
    cmp(rd, 32'h10);
    summarize();
  end
endmodule
bind dscs_seq dscs_checker u_chk (.pclk, .presetn, .psel, .penable, .paddr, .prdata, .pready, .pslverr,
  .intrq, .byte_tick, .dk_byte, .wr_gate, .step_out, .eng_id_req, .eng_rd_req, .eng_corr_req);
`default_nettype wire

// [hdl/dscs_regs.vh]
`ifndef DSCS_REGS_VH
`define DSCS_REGS_VH
// ==========================================================
// Register word indices
`define DSCS_R_DATA 3'h0
`define DSCS_R_ERRPC 3'h1
`define DSCS_R_SCNT 3'h2
`define DSCS_R_SNUM 3'h3
`define DSCS_R_CYLL 3'h4
`define DSCS_R_CYLH 3'h5
`define DSCS_R_SDH 3'h6
`define DSCS_R_STCMD 3'h7
// ==========================================================
// Status and error bit positions
`define DSCS_ST_BUSY 7
`define DSCS_ST_RDY 6
`define DSCS_ST_WF 5
`define DSCS_ST_SC 4
`define DSCS_ST_XFER 3
`define DSCS_ST_CORR 2
`define DSCS_ST_ERR 0
`define DSCS_ER_BAD 7
`define DSCS_ER_UNC 6
`define DSCS_ER_IDCRC 5
`define DSCS_ER_IDNF 4
`define DSCS_ER_ABRT 2
`define DSCS_ER_NODM 0
// ==========================================================
// Command opcodes and modifier bits
`define DSCS_OP_RESTORE 4'h1
`define DSCS_OP_SEEK 4'h7
`define DSCS_OP_READ 4'h2
`define DSCS_OP_WRITE 4'h3
`define DSCS_OP_FORMAT 4'h5
`define DSCS_CB_DMA 3
`define DSCS_CB_LONG 1
// ==========================================================
// Counts, field bytes and times
`define DSCS_INDEX_LIMIT 8'h80
`define DSCS_TRIES 5'h10
`define DSCS_FILL 8'h4e
`define DSCS_DATA_MARK 8'hf8
`define DSCS_GAP_SHORT 10'h00f
`define DSCS_GAP_LONG 10'h01e
`define DSCS_WG_LEAD 10'h003
`define DSCS_WG_TAIL 10'h003
`define DSCS_ZERO_PRE 10'h00c
`define DSCS_CHK_BYTES 10'h004
`define DSCS_ID_CHK 10'h002
`define DSCS_CLK_NS 10
`define DSCS_STEP_MIN_NS 35000
`define DSCS_STEP_UNIT_NS 500000
`define DSCS_STEP_PW_NS 1000
`endif

// [hdl/dscs_seq.v]
// Implementation choices: the APB register port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "dscs_regs.vh"
// Contract
// - Implied seeks use last stored stepping rate
// - Read: busy, precheck lines, abort on fault
// - Read seek timeout after 128 index pulses
// - Read retries sector up to 16 times
// - One auto-restore after 16 ID misses
// - ECC error: correct in buffer or uncorrectable
// - History kept; report only most severe error
// - Read long appends four check bytes
// - Write requests each buffer byte from host
// - Write: busy and precheck after buffer full
// - Write/format seek timeout aborts with interrupt
// - Write retries ID search up to 16 times
// - Write buffer on ID match, then interrupt
// - Write long takes host check bytes
// - Format loads one sector of interleave table
// - Format seek skips ID verification
// - Format: 4E to index, sectors, count down
// - Format backfills 4E, ends at index
// - Head byte MSB set marks bad block
// - Write gate 3 bytes lead/tail, 12 zeros
// - ID mark low bits carry cylinder 9:8
// - Post-data gap 15 or 30 bytes
// - DMA bit places interrupt around transfer
module dscs_seq #(
  parameter STEP_UNIT_CYC = `DSCS_STEP_UNIT_NS / `DSCS_CLK_NS
) (
  input wire pclk, // Bus clock
  input wire presetn, // Async reset
  input wire psel, // APB select
  input wire penable, // APB enable
  input wire pwrite, // APB direction
  input wire [11:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  output reg [31:0] prdata, // APB read data
  output wire pready, // APB ready
  output wire pslverr, // APB error
  output reg intrq, // Host interrupt
  output wire byte_transfer_request, // Buffer byte wanted
  input wire drv_ready, // Drive ready pin
  input wire drv_seek_done, // Seek complete pin
  input wire drv_write_fault, // Write fault pin
  input wire drv_index, // Index pin
  input wire drv_trk0, // Track zero pin
  output reg [3:0] drv_sel, // Drive select, one-hot
  output reg [2:0] head_sel, // Head select
  output reg step_out, // Step pulse
  output reg step_dir, // 1 = inward
  input wire byte_tick, // Next byte wanted
  output reg [7:0] dk_byte, // Byte to serializer
  output reg dk_gen_chk, // Serializer adds check
  output reg wr_gate, // Write gate
  output wire [9:0] tgt_cyl, // Target cylinder
  output wire [7:0] tgt_sec, // Target sector
  output wire rd_long, // Engine stores check bytes
  output reg eng_id_req, // Start ID search
  input wire eng_id_done, // ID search finished
  input wire [1:0] eng_id_stat, // 0 ok, 1 none, 2 bad CRC
  input wire eng_bad_block, // Found ID is bad block
  output reg eng_rd_req, // Start data field read
  input wire eng_rd_done, // Data read finished
  input wire [1:0] eng_rd_stat, // 0 ok, 1 no mark, 2 ECC
  output reg eng_corr_req, // Start correction
  input wire eng_corr_done, // Correction finished
  input wire eng_corr_ok, // Correction succeeded
  input wire eng_we, // Engine buffer write
  input wire [9:0] eng_addr, // Engine buffer address
  input wire [7:0] eng_wdata // Engine buffer data
);
  // ==========================================================
  // Constants and states
  localparam [19:0] STEP_MIN = `DSCS_STEP_MIN_NS / `DSCS_CLK_NS;
  localparam [19:0] STEP_PW = `DSCS_STEP_PW_NS / `DSCS_CLK_NS;
  localparam [19:0] STEP_UNIT = STEP_UNIT_CYC;
  localparam [3:0] S_IDLE = 4'h0, S_LOAD = 4'h1, S_CHECK = 4'h2, S_SEEK = 4'h3;
  localparam [3:0] S_SETTLE = 4'h4, S_RESTORE = 4'h5, S_ID = 4'h6, S_RDATA = 4'h7;
  localparam [3:0] S_ECC = 4'h8, S_XFER = 4'h9, S_WRITE = 4'ha, S_FPRE = 4'hb;
  localparam [3:0] S_FSEC = 4'hc, S_FFILL = 4'hd, S_FIN = 4'he;

  // Highest set bit wins: most severe error
  function [7:0] most_severe;
    input [7:0] h;
    integer i;
    begin
      most_severe = 8'h00;
      for (i = 0; i < 8; i = i + 1) begin
        if (h[i]) begin
          most_severe = 8'h01 << i;
        end
      end
    end
  endfunction

  // Sector size code to byte count
  function [9:0] sec_len;
    input [1:0] code;
    begin
      case (code)
        2'b01: sec_len = 10'h200;
        2'b11: sec_len = 10'h080;
        default: sec_len = 10'h100;
      endcase
    end
  endfunction

  // ==========================================================
  // Pin synchronisers
  reg [4:0] sync1, sync2;
  reg idx_d;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= 5'h00;
      sync2 <= 5'h00;
      idx_d <= 1'b0;
    end else begin
      sync1 <= {drv_trk0, drv_index, drv_write_fault, drv_seek_done, drv_ready};
      sync2 <= sync1;
      idx_d <= sync2[3];
    end
  end
  wire rdy_s = sync2[0];
  wire sc_s = sync2[1];
  wire wf_s = sync2[2];
  wire trk0_s = sync2[4];
  wire idx_edge = sync2[3] & ~idx_d;

  // ==========================================================
  // State
  reg [3:0] state;
  reg [7:0] err_reg, hist, precomp, scnt, snum, cyl_lo, cyl_hi, sdh, cmd;
  reg [3:0] rate;
  reg busy, corr, err_st, restored;
  reg [9:0] pos [0:3];
  reg [7:0] buf_mem [0:515];
  reg [9:0] ptr, bcnt, fsec;
  reg [4:0] tries;
  reg [7:0] idx_cnt;
  reg [19:0] tmr;
  reg [7:0] nb;
  reg ngen, ngate, nlast;

  wire [3:0] op = cmd[7:4];
  wire is_long = cmd[`DSCS_CB_LONG];
  wire [1:0] drv = sdh[4:3];
  wire [9:0] slen = sec_len(sdh[6:5]);
  wire [9:0] xlen = (is_long && op != `DSCS_OP_FORMAT) ? slen + `DSCS_CHK_BYTES : slen;
  wire [9:0] gap = (sdh[6:5] == 2'b01) ? `DSCS_GAP_LONG : `DSCS_GAP_SHORT;
  wire [9:0] cur = pos[drv];
  wire [19:0] period = (rate == 4'h0) ? STEP_MIN : rate * STEP_UNIT;
  wire [7:0] id_mark = {6'h3f, cyl_hi[1] ? 2'b00 : 2'b10} | {6'h00, 1'b0, cyl_hi[0]};
  assign tgt_cyl = {cyl_hi[1:0], cyl_lo};
  assign tgt_sec = snum;
  assign rd_long = is_long;
  assign byte_transfer_request = (state == S_LOAD) || (state == S_XFER);

  // ==========================================================
  // APB decode: zero wait, read data caught in setup
  wire setup = psel & ~penable;
  wire acc = psel & penable;
  wire bad_addr = (paddr[11:5] != 7'h00) || (paddr[1:0] != 2'b00);
  wire [2:0] ri = paddr[4:2];
  wire wr_acc = acc & pwrite & ~bad_addr;
  wire rd_acc = acc & ~pwrite & ~bad_addr;
  assign pready = 1'b1;
  assign pslverr = acc & bad_addr;
  wire host_byte = (state == S_LOAD && wr_acc && ri == `DSCS_R_DATA) ||
                   (state == S_XFER && rd_acc && ri == `DSCS_R_DATA);
  wire last_byte = host_byte && (ptr == xlen - 10'h001);
  wire [7:0] st = {busy, rdy_s, wf_s, sc_s, byte_transfer_request, corr, 1'b0, err_st};

  // ==========================================================
  // Disk byte stream
  always @* begin
    nb = 8'h00;
    ngen = 1'b0;
    ngate = 1'b1;
    nlast = 1'b0;
    if (state == S_WRITE) begin
      // Lead, 12 zeros, mark, data, check bytes, tail
      if (bcnt < `DSCS_WG_LEAD) begin
        ngate = 1'b0;
      end else if (bcnt < `DSCS_WG_LEAD + `DSCS_ZERO_PRE) begin
        nb = 8'h00;
      end else if (bcnt == `DSCS_WG_LEAD + `DSCS_ZERO_PRE) begin
        nb = `DSCS_DATA_MARK;
      end else if (bcnt < `DSCS_WG_LEAD + `DSCS_ZERO_PRE + 10'h001 + slen) begin
        nb = buf_mem[bcnt - `DSCS_WG_LEAD - `DSCS_ZERO_PRE - 10'h001];
      end else if (bcnt < `DSCS_WG_LEAD + `DSCS_ZERO_PRE + 10'h001 + slen + `DSCS_CHK_BYTES) begin
        nb = buf_mem[bcnt - `DSCS_WG_LEAD - `DSCS_ZERO_PRE - 10'h001];
        ngen = ~is_long;
      end else begin
        nb = 8'h00;
        nlast = (bcnt == `DSCS_WG_LEAD + `DSCS_ZERO_PRE + slen + `DSCS_CHK_BYTES + `DSCS_WG_TAIL);
      end
    end else begin
      // ID field, zero pad, mark, nulled data, check, gap
      case (bcnt)
        10'h000: nb = id_mark;
        10'h001: nb = cyl_lo;
        10'h002: nb = {buf_mem[{fsec[8:0], 1'b0}][7], 4'h0, sdh[2:0]};
        10'h003: nb = buf_mem[{fsec[8:0], 1'b1}];
        10'h004, 10'h005: ngen = 1'b1;
        default: begin
          if (bcnt < 10'h006 + `DSCS_ZERO_PRE) begin
            nb = 8'h00;
          end else if (bcnt == 10'h006 + `DSCS_ZERO_PRE) begin
            nb = `DSCS_DATA_MARK;
          end else if (bcnt < 10'h007 + `DSCS_ZERO_PRE + slen) begin
            nb = 8'h00;
          end else if (bcnt < 10'h007 + `DSCS_ZERO_PRE + slen + `DSCS_CHK_BYTES) begin
            ngen = 1'b1;
          end else begin
            nb = `DSCS_FILL;
            nlast = (bcnt == 10'h006 + `DSCS_ZERO_PRE + slen + `DSCS_CHK_BYTES + gap);
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Sequencer, registers, buffer and stepping
  integer k;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= S_IDLE;
      err_reg <= 8'h00; hist <= 8'h00; precomp <= 8'h00; scnt <= 8'h00;
      snum <= 8'h00; cyl_lo <= 8'h00; cyl_hi <= 8'h00; sdh <= 8'h00; cmd <= 8'h00;
      rate <= 4'h0; busy <= 1'b0; corr <= 1'b0; err_st <= 1'b0; restored <= 1'b0;
      ptr <= 10'h000; bcnt <= 10'h000; fsec <= 10'h000; tries <= 5'h00;
      idx_cnt <= 8'h00; tmr <= 20'h00000; prdata <= 32'h00000000; intrq <= 1'b0;
      drv_sel <= 4'h0; head_sel <= 3'h0; step_out <= 1'b0; step_dir <= 1'b0;
      dk_byte <= 8'h00; dk_gen_chk <= 1'b0; wr_gate <= 1'b0;
      eng_id_req <= 1'b0; eng_rd_req <= 1'b0; eng_corr_req <= 1'b0;
      for (k = 0; k < 4; k = k + 1) begin
        pos[k] <= 10'h000;
      end
    end else begin
      eng_id_req <= 1'b0;
      eng_rd_req <= 1'b0;
      eng_corr_req <= 1'b0;
      drv_sel <= 4'h1 << drv;
      head_sel <= sdh[2:0];
      // Step timer: pulse width, then rest of period
      if (tmr != 20'h00000) begin
        tmr <= tmr - 20'h00001;
      end
      if (tmr <= (period > STEP_PW ? period - STEP_PW : 20'h00000)) begin
        step_out <= 1'b0;
      end
      if (setup) begin
        case (ri)
          `DSCS_R_DATA: prdata <= {24'h000000, buf_mem[ptr]};
          `DSCS_R_ERRPC: prdata <= {24'h000000, err_reg};
          `DSCS_R_SCNT: prdata <= {24'h000000, scnt};
          `DSCS_R_SNUM: prdata <= {24'h000000, snum};
          `DSCS_R_CYLL: prdata <= {24'h000000, cyl_lo};
          `DSCS_R_CYLH: prdata <= {24'h000000, cyl_hi};
          `DSCS_R_SDH: prdata <= {24'h000000, sdh};
          default: prdata <= {24'h000000, st};
        endcase
        if (bad_addr) begin
          prdata <= 32'h00000000;
        end
      end
      if (rd_acc && ri == `DSCS_R_STCMD) begin
        intrq <= 1'b0;
      end
      // Task file writes are refused while a command runs
      if (wr_acc && state == S_IDLE) begin
        case (ri)
          `DSCS_R_ERRPC: precomp <= pwdata[7:0];
          `DSCS_R_SCNT: scnt <= pwdata[7:0];
          `DSCS_R_SNUM: snum <= pwdata[7:0];
          `DSCS_R_CYLL: cyl_lo <= pwdata[7:0];
          `DSCS_R_CYLH: cyl_hi <= pwdata[7:0];
          `DSCS_R_SDH: sdh <= pwdata[7:0];
          `DSCS_R_STCMD: begin
            cmd <= pwdata[7:0];
            intrq <= 1'b0;
            err_reg <= 8'h00; hist <= 8'h00; corr <= 1'b0; err_st <= 1'b0;
            restored <= 1'b0; tries <= 5'h00; ptr <= 10'h000;
            case (pwdata[7:4])
              `DSCS_OP_RESTORE, `DSCS_OP_SEEK: begin
                rate <= pwdata[3:0];
                intrq <= 1'b1;
              end
              `DSCS_OP_READ: begin
                busy <= 1'b1;
                state <= S_CHECK;
              end
              `DSCS_OP_WRITE, `DSCS_OP_FORMAT: state <= S_LOAD;
              default: state <= S_IDLE;
            endcase
          end
          default: ;
        endcase
      end
      if (host_byte) begin
        ptr <= ptr + 10'h001;
        if (state == S_LOAD) begin
          buf_mem[ptr] <= pwdata[7:0];
        end
      end
      if (eng_we && (state == S_RDATA || state == S_ECC)) begin
        buf_mem[eng_addr] <= eng_wdata;
      end
      if (byte_tick) begin
        dk_byte <= `DSCS_FILL;
        dk_gen_chk <= 1'b0;
        wr_gate <= (state == S_FPRE) || (state == S_FFILL);
      end
      case (state)
        S_IDLE: ;
        S_LOAD: begin
          if (last_byte) begin
            busy <= 1'b1;
            state <= S_CHECK;
          end
        end
        S_CHECK: begin
          if (!rdy_s || !sc_s || wf_s) begin
            err_reg[`DSCS_ER_ABRT] <= 1'b1;
            err_st <= 1'b1;
            state <= (op == `DSCS_OP_READ) ? S_XFER : S_FIN;
            ptr <= 10'h000;
          end else begin
            state <= S_SEEK;
          end
        end
        S_SEEK: begin
          idx_cnt <= 8'h00;
          if (cur == tgt_cyl) begin
            state <= S_SETTLE;
          end else if (tmr == 20'h00000) begin
            step_out <= 1'b1;
            step_dir <= (tgt_cyl > cur);
            tmr <= period;
            pos[drv] <= (tgt_cyl > cur) ? cur + 10'h001 : cur - 10'h001;
          end
        end
        S_SETTLE: begin
          if (idx_edge) begin
            idx_cnt <= idx_cnt + 8'h01;
          end
          if (sc_s && tmr == 20'h00000) begin
            tries <= 5'h00;
            bcnt <= 10'h000;
            fsec <= 10'h000;
            if (op == `DSCS_OP_FORMAT) begin
              state <= S_FPRE;
            end else begin
              eng_id_req <= 1'b1;
              state <= S_ID;
            end
          end else if (idx_cnt == `DSCS_INDEX_LIMIT) begin
            err_reg[`DSCS_ER_ABRT] <= 1'b1;
            err_st <= (op != `DSCS_OP_FORMAT);
            ptr <= 10'h000;
            state <= (op == `DSCS_OP_READ) ? S_XFER : S_FIN;
          end
        end
        S_RESTORE: begin
          // Step out on each seek complete until track zero
          if (trk0_s) begin
            pos[drv] <= 10'h000;
            restored <= 1'b1;
            state <= S_SEEK;
          end else if (sc_s && tmr == 20'h00000 && !step_out) begin
            step_out <= 1'b1;
            step_dir <= 1'b0;
            tmr <= STEP_PW;
          end
        end
        S_ID: begin
          if (eng_id_done) begin
            if (eng_id_stat == 2'b00 && eng_bad_block) begin
              hist[`DSCS_ER_BAD] <= 1'b1;
              err_reg <= most_severe(hist | 8'h80);
              err_st <= 1'b1;
              ptr <= 10'h000;
              state <= (op == `DSCS_OP_READ) ? S_XFER : S_FIN;
            end else if (eng_id_stat == 2'b00) begin
              bcnt <= 10'h000;
              if (op == `DSCS_OP_READ) begin
                eng_rd_req <= 1'b1;
                state <= S_RDATA;
              end else begin
                state <= S_WRITE;
              end
            end else begin
              hist[(eng_id_stat == 2'b10) ? `DSCS_ER_IDCRC : `DSCS_ER_IDNF] <= 1'b1;
              tries <= tries + 5'h01;
              if (tries != `DSCS_TRIES - 5'h01) begin
                eng_id_req <= 1'b1;
              end else if (!restored) begin
                tries <= 5'h00;
                state <= S_RESTORE;
              end else begin
                err_reg <= most_severe(hist | (eng_id_stat == 2'b10 ? 8'h20 : 8'h10));
                err_st <= 1'b1;
                ptr <= 10'h000;
                state <= (op == `DSCS_OP_READ) ? S_XFER : S_FIN;
              end
            end
          end
        end
        S_RDATA, S_ECC: begin
          if ((state == S_RDATA && eng_rd_done && eng_rd_stat == 2'b00) ||
              (state == S_ECC && eng_corr_done && eng_corr_ok)) begin
            corr <= (state == S_ECC);
            ptr <= 10'h000;
            intrq <= ~cmd[`DSCS_CB_DMA];
            busy <= 1'b0;
            state <= S_XFER;
          end else if (state == S_RDATA && eng_rd_done && eng_rd_stat == 2'b10) begin
            eng_corr_req <= 1'b1;
            state <= S_ECC;
          end else if (eng_rd_done || eng_corr_done) begin
            hist[(state == S_ECC) ? `DSCS_ER_UNC : `DSCS_ER_NODM] <= 1'b1;
            tries <= tries + 5'h01;
            if (tries != `DSCS_TRIES - 5'h01) begin
              eng_id_req <= 1'b1;
              state <= S_ID;
            end else begin
              // Buffer keeps the last failing data for the host
              err_reg <= most_severe(hist | ((state == S_ECC) ? 8'h40 : 8'h01));
              err_st <= 1'b1;
              ptr <= 10'h000;
              state <= S_XFER;
            end
          end
        end
        S_XFER: begin
          busy <= 1'b0;
          if (last_byte) begin
            intrq <= intrq | cmd[`DSCS_CB_DMA] | err_st;
            state <= S_IDLE;
          end
        end
        S_WRITE, S_FSEC: begin
          if (byte_tick) begin
            dk_byte <= nb;
            dk_gen_chk <= ngen;
            wr_gate <= ngate;
            bcnt <= bcnt + 10'h001;
            if (nlast) begin
              bcnt <= 10'h000;
              if (state == S_WRITE) begin
                state <= S_FIN;
              end else begin
                scnt <= scnt - 8'h01;
                fsec <= fsec + 10'h001;
                state <= (scnt == 8'h01) ? S_FFILL : S_FSEC;
              end
            end
          end
        end
        S_FPRE: begin
          if (idx_edge) begin
            state <= (scnt == 8'h00) ? S_FFILL : S_FSEC;
          end
        end
        S_FFILL: begin
          if (idx_edge) begin
            state <= S_FIN;
          end
        end
        S_FIN: begin
          busy <= 1'b0;
          intrq <= 1'b1;
          state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire
